/* File: hdl/ump_defs.vh */
// constants for the multi-phy port map block: register offsets, field
// positions, selection codes, reset values and poll timing.
// included by the port map decoder and the port map top.
`ifndef UMP_DEFS_VH
`define UMP_DEFS_VH

// register offsets on the plain register port
`define UMP_ADDR_W        12
`define UMP_OFF_MAP_CFG   12'h112
`define UMP_OFF_QUE_CFG   12'h114
`define UMP_OFF_STATUS    12'h116
`define UMP_OFF_AVAIL0    12'h118
`define UMP_OFF_AVAIL1    12'h11a
`define UMP_OFF_AVAIL2    12'h11c
`define UMP_OFF_AVAIL3    12'h11e

// reset values
`define UMP_MAP_CFG_RST   16'h0000
`define UMP_QUE_CFG_RST   4'h4

// field positions
`define UMP_SEL_HI        3
`define UMP_SEL_LO        0
`define UMP_NORM_BIT      0
`define UMP_PROG_HI       3
`define UMP_PROG_LO       1

// port map selections
`define UMP_SEL_A0C4      4'h0
`define UMP_SEL_A1C4      4'h2
`define UMP_SEL_A2C4      4'h5
`define UMP_SEL_A4C2      4'h3
`define UMP_SEL_A3C4      4'hb
`define UMP_SEL_A4C4      4'h8

// queue counts per phy
`define UMP_Q_FOUR        3'h4
`define UMP_Q_TWO         3'h2
`define UMP_Q_NONE        3'h0

// cycles the address is held before the clav level is taken; covers the
// three-stage input synchroniser
`define UMP_SETTLE        3'h4

// clav/enable lines on the pins
`define UMP_LINES         4

`endif

/* File: hdl/ump_map_dec.v */
// port number to clav/enable line and address decoder.
// purely combinational; fed from registered port number and selection.
`timescale 1ns/1ns
`include "ump_defs.vh"

module ump_map_dec (
  // selection and port
  input  wire [3:0] sel,
  input  wire [5:0] port,
  // mapping
  output reg        valid,
  output reg  [1:0] line,
  output reg  [3:0] addr
);

  always @* begin
    valid = 1'b0;
    line  = 2'h0;
    addr  = 4'h0;
    case (sel)
      `UMP_SEL_A0C4: begin
        // one level-1 phy per line, port number follows the line
        valid = (port[5:3] == 3'h0) && !port[0]; // RQ3 RQ4
        line  = port[2:1];
        addr  = 4'h0;
      end
      `UMP_SEL_A1C4: begin
        valid = (port[5:4] == 2'h0) && !port[0]; // RQ5
        line  = port[3:2];
        addr  = {2'h0, port[1], 1'b0};
      end
      `UMP_SEL_A2C4: begin
        valid = !port[5] && !port[0]; // RQ6
        line  = port[4:3];
        addr  = {1'b0, port[2:1], 1'b0};
      end
      `UMP_SEL_A4C2: begin
        valid = !port[5]; // RQ7
        line  = {1'b0, port[4]};
        addr  = port[3:0];
      end
      `UMP_SEL_A3C4: begin
        valid = !port[0]; // RQ8
        line  = port[5:4];
        addr  = {port[3:1], 1'b0};
      end
      `UMP_SEL_A4C4: begin
        valid = 1'b1; // RQ9 RQ1
        line  = port[5:4];
        addr  = port[3:0];
      end
      default: begin
        // unknown selection maps nothing, so nothing is driven
        valid = 1'b0; // RQ13
      end
    endcase
  end

endmodule

/* File: hdl/ump_port_map.v */
// multi-phy port map top: register port, clav poller, enable driver.
// assumes one 25 mhz clock shared with the utopia interface; clav pins
// arrive asynchronous and are synchronised here.
// a map write drops any enable at once, so software should change the map
// only while the cell logic is idle.
//
// Summary of operation
// RQ1: up to 64 phy ports, each with an internal port number.
// RQ2: selection bits 3:0 of port map config pick the line/address pairing.
// RQ3: 0000: ports 0,2,4,6 on lines 0-3 at address 0, rest unused.
// RQ4: with fewer level-1 phys, port number must match the wired clav line.
// RQ5: 0010: two even ports per line, addresses 0 and 2.
// RQ6: 0101: four even ports per line, addresses 0 to 6.
// RQ7: 0011: sixteen ports per line on two lines, address equals port.
// RQ8: 1011: eight even ports per line, address equals port low bits.
// RQ9: 1000: sixteen ports per line on four lines, address equals port.
// RQ10: 1000 gives two queues in normal mode, else programmed count.
// RQ11: selections 0000,0010,0101,0011,1011 give four queues per phy.
// RQ12: unused clav inputs are tied low by the board.
// RQ13: only mapped ports are polled, enabled and addressed.
`timescale 1ns/1ns
`include "ump_defs.vh"

module ump_port_map #(
  parameter SETTLE = `UMP_SETTLE
) (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  // register port
  input  wire [11:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // utopia pins
  input  wire [3:0]  u_clav,
  output reg  [3:0]  u_enb_n,
  output reg  [3:0]  u_addr,
  // cell transfer side
  input  wire        xfer_en,
  output wire        xfer_active,
  output reg  [5:0]  xfer_port,
  // status to queue logic
  output reg  [63:0] cell_avail,
  output reg  [2:0]  queues_per_phy,
  output wire        map_valid
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [1:0] S_SCAN   = 2'h0;
  localparam [1:0] S_SETTLE = 2'h1;
  localparam [1:0] S_SAMPLE = 2'h2;
  localparam [1:0] S_XFER   = 2'h3;

  // last count of the settle wait; SETTLE below four lets a stale clav
  // level through the synchroniser
  localparam [2:0] SETTLE_LAST = SETTLE - 3'h1;

  // ------------------------------------------------------------
  // queue allocation
  // ------------------------------------------------------------
  function [2:0] ump_queues;
    input [3:0] sel;
    input       normal;
    input [2:0] prog;
    begin
      case (sel)
        `UMP_SEL_A4C4: ump_queues = normal ? `UMP_Q_TWO : prog; // RQ10
        `UMP_SEL_A0C4,
        `UMP_SEL_A1C4,
        `UMP_SEL_A2C4,
        `UMP_SEL_A4C2,
        `UMP_SEL_A3C4: ump_queues = `UMP_Q_FOUR; // RQ11
        default:       ump_queues = `UMP_Q_NONE;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // register address decode
  // ------------------------------------------------------------
  // one compare shared by every write enable keeps the offsets in one place
  // and makes a near miss land nowhere rather than alias
  function ump_reg_hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      ump_reg_hit = (addr == off);
    end
  endfunction

  // ------------------------------------------------------------
  // enable pattern
  // ------------------------------------------------------------
  // one active-low line, every other line left idle
  function [3:0] ump_enb_mask;
    input [1:0] line;
    begin
      ump_enb_mask = ~(4'h1 << line);
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [15:0] map_cfg_q;
  reg  [3:0]  que_cfg_q;
  reg  [1:0]  state_q;
  reg  [5:0]  port_q;
  reg  [2:0]  cnt_q;
  reg  [1:0]  line_q;
  wire [3:0]  clav_lvl;
  reg  [15:0] rdata_d;
  wire [15:0] status_word;
  wire        que_wr;
  wire [3:0]  sel;
  wire        dec_valid;
  wire [1:0]  dec_line;
  wire [3:0]  dec_addr;
  wire        cfg_wr;
  wire        cur_clav;

  assign sel         = map_cfg_q[`UMP_SEL_HI:`UMP_SEL_LO]; // RQ2
  assign cfg_wr      = reg_wr && ump_reg_hit(reg_addr, `UMP_OFF_MAP_CFG);
  assign que_wr      = reg_wr && ump_reg_hit(reg_addr, `UMP_OFF_QUE_CFG);
  assign cur_clav    = clav_lvl[line_q];
  assign xfer_active = (state_q == S_XFER);
  assign map_valid   = (ump_queues(sel, 1'b1, 3'h1) != `UMP_Q_NONE);
  // status fields, msb first: queue count, map valid, line, state, port
  assign status_word = {queues_per_phy, map_valid, line_q, state_q, 2'h0, port_q};

  // ------------------------------------------------------------
  // port decoder
  // ------------------------------------------------------------
  ump_map_dec u_dec (
    .sel   (sel),
    .port  (port_q),
    .valid (dec_valid),
    .line  (dec_line),
    .addr  (dec_addr)
  );

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      map_cfg_q <= `UMP_MAP_CFG_RST;
      que_cfg_q <= `UMP_QUE_CFG_RST;
    end else begin
      if (cfg_wr)
        map_cfg_q <= reg_wdata;
      if (que_wr)
        que_cfg_q <= reg_wdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // queue count
  // ------------------------------------------------------------
  // registered behind the configuration so the queue logic sees a clean
  // value; it trails a write by one clock, which software must allow
  // before it relies on the new count
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      queues_per_phy <= `UMP_Q_NONE;
    else
      queues_per_phy <= ump_queues(sel, que_cfg_q[`UMP_NORM_BIT],
                                   que_cfg_q[`UMP_PROG_HI:`UMP_PROG_LO]); // RQ10 RQ11
  end

  // ------------------------------------------------------------
  // register reads, data only in the cycle after the strobe
  // ------------------------------------------------------------
  always @* begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `UMP_OFF_MAP_CFG: rdata_d = map_cfg_q;
      `UMP_OFF_QUE_CFG: rdata_d = {12'h000, que_cfg_q};
      `UMP_OFF_STATUS:  rdata_d = status_word;
      `UMP_OFF_AVAIL0:  rdata_d = cell_avail[15:0];
      `UMP_OFF_AVAIL1:  rdata_d = cell_avail[31:16];
      `UMP_OFF_AVAIL2:  rdata_d = cell_avail[47:32];
      `UMP_OFF_AVAIL3:  rdata_d = cell_avail[63:48];
      default:          rdata_d = 16'h0000;
    endcase
  end

  // zero outside the read cycle, so read data can be or-ed with other slaves
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 16'h0000;
  end

  // ------------------------------------------------------------
  // clav synchroniser; a level counts once stages two and three agree
  // ------------------------------------------------------------
  // one chain per line; the held level keeps a half-settled pin from
  // toggling the flag, at the price of one more cycle of delay, which the
  // settle wait of the poller has to cover
  genvar gi;
  generate
    for (gi = 0; gi < `UMP_LINES; gi = gi + 1) begin : g_clav
      reg sync1_q;
      reg sync2_q;
      reg sync3_q;
      reg level_q;
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
          sync3_q <= 1'b0;
          level_q <= 1'b0;
        end else begin
          sync1_q <= u_clav[gi];
          sync2_q <= sync1_q;
          sync3_q <= sync2_q;
          level_q <= (sync2_q & sync3_q) | (level_q & (sync2_q | sync3_q));
        end
      end
      assign clav_lvl[gi] = level_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // poller: walks port numbers, skipping the ones the map leaves out
  // ------------------------------------------------------------
  // a config write restarts the walk and drops every stale flag, since a
  // flag taken under the old map may belong to a different phy now
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q    <= S_SCAN;
      port_q     <= 6'h00;
      cnt_q      <= 3'h0;
      line_q     <= 2'h0;
      u_addr     <= 4'h0;
      u_enb_n    <= 4'hf;
      xfer_port  <= 6'h00;
      cell_avail <= 64'h0;
    end else if (cfg_wr) begin
      state_q    <= S_SCAN;
      port_q     <= 6'h00;
      cnt_q      <= 3'h0;
      u_enb_n    <= 4'hf;
      cell_avail <= 64'h0;
    end else begin
      case (state_q)
        S_SCAN: begin
          u_enb_n <= 4'hf;
          // an unmapped port costs one cycle, a mapped one the settle wait
          if (dec_valid) begin
            u_addr  <= dec_addr; // RQ13
            line_q  <= dec_line;
            cnt_q   <= 3'h0;
            state_q <= S_SETTLE;
          end else begin
            port_q <= port_q + 6'h01; // RQ13
          end
        end
        S_SETTLE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == SETTLE_LAST)
            state_q <= S_SAMPLE;
        end
        S_SAMPLE: begin
          // the flag follows the pin whether or not a transfer is wanted
          cell_avail[port_q] <= cur_clav; // RQ1
          if (xfer_en && cur_clav) begin
            u_enb_n         <= ump_enb_mask(line_q); // RQ2
            xfer_port       <= port_q;
            state_q         <= S_XFER;
          end else begin
            port_q  <= port_q + 6'h01;
            state_q <= S_SCAN;
          end
        end
        S_XFER: begin
          // enable is held until the cell logic lets go
          // polling stops meanwhile; cell logic that never lets go starves all
          if (!xfer_en) begin
            u_enb_n <= 4'hf;
            port_q  <= port_q + 6'h01;
            state_q <= S_SCAN;
          end
        end
        default: begin
          state_q <= S_SCAN;
          u_enb_n <= 4'hf;
        end
      endcase
    end
  end

endmodule

/* File: sim/ump_phy_model.sv */
// phy side model: one clav line per group, flags looked up by address.
// assumes the bench sets the flag table and the mask of wired lines.
`timescale 1ns/1ns
module ump_phy_model (
  // pins
  input  logic [3:0]  u_addr,
  output logic [3:0]  u_clav,
  // setup
  input  logic [63:0] cells,
  input  logic [3:0]  used
);
  // unwired clav lines sit at ground, never at a stale level
  always @* begin
    for (int l = 0; l < 4; l++) begin
      u_clav[l] = used[l] & cells[l * 16 + u_addr];
    end
  end
endmodule

/* File: sim/ump_port_map_asserts.sv */
// checker for the port map top, bound to its ports.
// assumes the register port keeps the one-cycle strobe contract.
`timescale 1ns/1ns
module ump_port_map_asserts (
  // clock and reset
  input logic        clock,
  input logic        rstn,
  // register port
  input logic [11:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  // pins and status
  input logic [3:0]  u_enb_n,
  input logic [3:0]  u_addr,
  input logic        xfer_en,
  input logic [63:0] cell_avail,
  input logic [2:0]  queues_per_phy,
  input logic        map_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [3:0] sel_q;
  logic       ok;
  wire        cfg_wr = reg_wr && reg_addr == 12'h112;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_q <= 4'h0;
    end else if (cfg_wr) begin
      sel_q <= reg_wdata[3:0];
    end
  end
  // legal address and line while an enable is low
  always @* begin
    case (sel_q)
      4'h0: ok = u_addr == 4'h0;
      4'h2: ok = (u_addr & 4'hd) == 4'h0;
      4'h5: ok = (u_addr & 4'h9) == 4'h0;
      4'h3: ok = u_enb_n[3:2] == 2'b11;
      4'hb: ok = !u_addr[0];
      4'h8: ok = 1'b1;
      default: ok = 1'b0;
    endcase
  end
  sequence s_four_wr;
    cfg_wr && reg_wdata[3:0] inside {4'h0, 4'h2, 4'h5, 4'h3, 4'hb};
  endsequence
  sequence s_enb_rise;
    u_enb_n == 4'hf ##1 u_enb_n != 4'hf;
  endsequence
  a_enb_one_hot: assert property ($countones(~u_enb_n) <= 1)
    else $error("enable not one-hot");
  a_addr_in_range: assert property (u_enb_n != 4'hf |-> ok)
    else $error("enable or address outside selection");
  a_four_queues: assert property (s_four_wr |-> ##[1:3] queues_per_phy == 3'h4)
    else $error("queue count not four");
  a_unknown_idle: assert property (!map_valid ##1 !map_valid |-> u_enb_n == 4'hf)
    else $error("enable under unknown selection");
  a_cfg_drops: assert property (cfg_wr |-> ##[1:2] (u_enb_n == 4'hf && cell_avail == 64'h0))
    else $error("config write kept enable or flags");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside its cycle");
  a_enb_cause: assert property (s_enb_rise |-> $past(xfer_en))
    else $error("enable without transfer request");
  a_enb_hold: assert property (u_enb_n != 4'hf && xfer_en && !reg_wr |=> $stable(u_enb_n) && $stable(u_addr))
    else $error("enable or address moved in transfer");
endmodule
bind ump_port_map ump_port_map_asserts u_chk (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .u_enb_n(u_enb_n),
  .u_addr(u_addr), .xfer_en(xfer_en), .cell_avail(cell_avail), .queues_per_phy(queues_per_phy),
  .map_valid(map_valid));

/* File: sim/testbench.sv */
// self-checking bench for the port map top with a phy model on the pins.
// assumes one 25 mhz clock; transfers are requested at random.
`timescale 1ns/1ns
module testbench;
  logic        clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, xfer_en = 0;
  logic [11:0] reg_addr = 12'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, rd_q;
  logic [3:0]  u_clav, u_enb_n, u_addr, used = 4'hf;
  logic [63:0] cell_avail, cells = 64'h0, exp_q;
  logic [5:0]  xfer_port;
  logic [2:0]  queues_per_phy;
  logic        xfer_active, map_valid;
  logic [3:0]  cur_sel = 4'h0;
  logic [6:0]  xm;
  int          failures = 0, checks = 0, cycles = 0, seed = 30385;
  logic [3:0]  sels [6] = '{4'h0, 4'h2, 4'h5, 4'h3, 4'hb, 4'h8};
  always #20 clock = ~clock;
  ump_port_map uut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .u_clav(u_clav), .u_enb_n(u_enb_n),
    .u_addr(u_addr), .xfer_en(xfer_en), .xfer_active(xfer_active), .xfer_port(xfer_port),
    .cell_avail(cell_avail), .queues_per_phy(queues_per_phy), .map_valid(map_valid));
  ump_phy_model phy (.u_addr(u_addr), .u_clav(u_clav), .cells(cells), .used(used));
  // {mapped, line, address} of a port
  function automatic logic [6:0] map(input logic [3:0] s, input logic [5:0] p);
    case (s)
      4'h0: map = {!p[0] && p < 8, p[2:1], 4'h0};
      4'h2: map = {!p[0] && p < 16, p[3:2], p[3:0] & 4'h2};
      4'h5: map = {!p[0] && p < 32, p[4:3], p[3:0] & 4'h6};
      4'h3: map = {p < 32, 1'b0, p[4], p[3:0]};
      4'hb: map = {!p[0], p[5:4], p[3:0] & 4'he};
      4'h8: map = {1'b1, p[5:4], p[3:0]};
      default: map = 7'h0;
    endcase
  endfunction
  function automatic logic [63:0] avail(input logic [3:0] s);
    logic [6:0] m;
    for (int i = 0; i < 64; i++) begin
      m = map(s, 6'(i));
      avail[i] = m[6] & used[m[5:4]] & cells[{m[5:4], m[3:0]}];
    end
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_q = reg_rdata;
  endtask
  task automatic results;
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // short random transfer requests; a hang ends in the report
  always @(posedge clock) begin
    xfer_en <= ($random(seed) & 1) == 1;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results;
    end
  end
  // a live transfer sits on the mapped line and address of a flagged port
  always @(negedge clock) begin
    if (rstn && xfer_active === 1'b1) begin
      xm = map(cur_sel, xfer_port);
      check({xm[6], cell_avail[xfer_port], u_enb_n, u_addr}, {2'b11, ~(4'h1 << xm[5:4]), xm[3:0]});
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(12'h112);
    check(rd_q, 16'h0);
    rd(12'h114);
    check(rd_q, 16'h4);
    rd(12'h116);
    check(rd_q[15:12], 4'h9);
    rd(12'h120);
    check(rd_q, 16'h0);
    for (int k = 0; k < 6; k++) begin
      @(negedge clock);
      cells = {$random(seed), $random(seed)};
      used = sels[k] == 4'h3 ? 4'h3 : 4'hf;
      wr(12'h112, {12'h0, sels[k]});
      cur_sel = sels[k];
      rd(12'h112);
      check(rd_q, {12'h0, sels[k]});
      repeat (1000) @(posedge clock);
      @(negedge clock);
      exp_q = avail(sels[k]);
      check(cell_avail, exp_q);
      rd(12'h118 + 12'(2 * (k % 4)));
      check(rd_q, exp_q[16 * (k % 4) +: 16]);
      check(queues_per_phy, sels[k] == 4'h8 ? 3'h2 : 3'h4);
    end
    wr(12'h114, 16'h6);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(queues_per_phy, 3'h3);
    wr(12'h114, 16'h7);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(queues_per_phy, 3'h2);
    wr(12'h112, 16'h1);
    cur_sel = 4'h1;
    repeat (200) @(posedge clock);
    @(negedge clock);
    check({map_valid, queues_per_phy, u_enb_n, cell_avail}, {1'b0, 3'h0, 4'hf, 64'h0});
    rd(12'h116);
    check(rd_q[15:12], 4'h0);
    results;
  end
endmodule
